// File: hdl/timer2_pkg.sv
// package: register map, field positions, reset values and timing for the capture/reload timer
package timer2_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] OFF_CONTROL      = 8'h00_c8;
    localparam logic [7:0] OFF_MODE_CONTROL = 8'h00_c9;
    localparam logic [7:0] OFF_RELOAD_LOW   = 8'h00_ca;
    localparam logic [7:0] OFF_RELOAD_HIGH  = 8'h00_cb;
    localparam logic [7:0] OFF_COUNT_LOW    = 8'h00_cc;
    localparam logic [7:0] OFF_COUNT_HIGH   = 8'h00_cd;
    localparam logic [7:0] OFF_IRQ_STATUS   = 8'h00_ce;
    localparam logic [7:0] OFF_IRQ_MASK     = 8'h00_cf;

    // control register fields
    localparam int BIT_CAP_RELOAD   = 0;
    localparam int BIT_COUNT_SRC    = 1;
    localparam int BIT_RUN          = 2;
    localparam int BIT_EXT_ENABLE   = 3;
    localparam int BIT_TX_BAUD      = 4;
    localparam int BIT_RX_BAUD      = 5;
    localparam int BIT_EXT_FLAG     = 6;
    localparam int BIT_OVF_FLAG     = 7;

    // mode control field
    localparam int BIT_CLOCK_OUT_EN = 1;

    // interrupt status fields
    localparam int IRQ_OVERFLOW     = 0;
    localparam int IRQ_TRIGGER      = 1;
    localparam int IRQ_CAPTURE      = 2;

    // reset values
    localparam logic [7:0] RST_CONTROL      = 8'h00_00;
    localparam logic [7:0] RST_MODE_CONTROL = 8'h00_00;
    localparam logic [7:0] RST_RELOAD       = 8'h00_00;
    localparam logic [7:0] RST_COUNT        = 8'h00_00;
    localparam logic [2:0] RST_IRQ          = 3'h0;

    // peripheral clock: one tick per 12 system clocks in 12T, per 6 in 6T
    localparam int TICKS_12T        = 12;
    localparam int TICKS_6T         = 6;

    typedef enum logic [1:0] {
        MODE_RELOAD_TYPE_UNUSED
    } unused_type;

endpackage : timer2_pkg

// File: hdl/timer2_capture_reload_clockout.sv
// 16-bit timer with capture, auto-reload and clock-out
//
// What this block does
// - enabled trigger falling edge sets trigger flag
// - disabled trigger edges are fully ignored
// - enabled trigger edge captures or reloads
// - run bit low halts counting; an enabled trigger still reloads count outside capture mode
// - source select: peripheral clock or pin edges
// - select bit picks reload or capture
// - any baud select forces auto-reload mode
// - clock-out enable drives count pin only when the peripheral clock is the count source
// - capture copies count low byte
// - reload low byte comes from low register
// - clock-out is a 50 percent square wave
// - clock-out and baud overflow raise no interrupt
// - trigger still sets flag in clock-out
// - output frequency set by reload value
// - six-cycle bit low doubles output rate
`timescale 1ns/10ps
`default_nettype none

module timer2_capture_reload_clockout
    import timer2_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    input  wire logic       i_six_cycle_mode,
    input  wire logic       i_trigger_pin,
    input  wire logic       i_external_count_pin,
    output logic            o_external_count_pin,
    output logic            o_external_count_pin_oe,
    output logic            o_overflow_pulse,
    output logic            o_irq
);

    logic [7:0]  control_reg;
    logic [7:0]  mode_reg;
    logic [7:0]  reload_low_reg;
    logic [7:0]  reload_high_reg;
    logic [15:0] count_reg;
    logic [2:0]  irq_status_reg;
    logic [2:0]  irq_mask_reg;
    logic [3:0]  presc_reg;
    logic        clk_out_reg;
    logic        ovf_pulse_reg;
    logic [1:0]  trig_sync_reg;
    logic        trig_last_reg;
    logic [1:0]  cnt_sync_reg;
    logic        cnt_last_reg;
    logic [1:0]  six_sync_reg;
    logic [7:0]  rdata_reg;

    logic        periph_tick;
    logic        pin_tick;
    logic        inc;
    logic        overflow;
    logic        trig_fall;
    logic        force_reload;
    logic        capture_mode;
    logic        clock_out_mode;
    logic        capture_evt;
    logic        reload_evt;
    logic        wr_control;
    logic        rd_status;
    logic [3:0]  presc_top;

    // one address hit test shared by the control, reload, count and status decodes
    // keeps the strobe and the address compare in one place
    function automatic logic hit(
        input logic       strobe,
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        return strobe & (addr == offset);
    endfunction

    // the clock-mode select comes from outside this clock domain,
    // so it passes two flops before the prescaler reads it;
    // a change therefore takes effect two clocks late, which only
    // stretches one peripheral tick and never shortens one
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            six_sync_reg <= 2'h0;
        else
            six_sync_reg <= {six_sync_reg[0], i_six_cycle_mode};
    end

    // pins cross into the clock domain through two flops each
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            trig_sync_reg <= 2'h0;
            trig_last_reg <= 1'b0;
            cnt_sync_reg  <= 2'h0;
            cnt_last_reg  <= 1'b0;
        end
        else
        begin
            trig_sync_reg <= {trig_sync_reg[0], i_trigger_pin};
            trig_last_reg <= trig_sync_reg[1];
            cnt_sync_reg  <= {cnt_sync_reg[0], i_external_count_pin};
            cnt_last_reg  <= cnt_sync_reg[1];
        end
    end

    // mode decode
    assign force_reload   = control_reg[BIT_TX_BAUD] | control_reg[BIT_RX_BAUD];
    assign capture_mode   = control_reg[BIT_CAP_RELOAD] & ~force_reload;
    assign clock_out_mode = mode_reg[BIT_CLOCK_OUT_EN] & ~control_reg[BIT_COUNT_SRC];
    assign trig_fall      = trig_last_reg & ~trig_sync_reg[1] & control_reg[BIT_EXT_ENABLE];
    assign capture_evt    = trig_fall & capture_mode;
    assign reload_evt     = (trig_fall & ~capture_mode) | (overflow & ~capture_mode);

    // peripheral tick: 6T when six-cycle bit is low, else 12T
    // the prescaler wraps at top, so a tick lasts top plus one clocks
    assign presc_top   = six_sync_reg[1] ? 4'(TICKS_12T - 1) : 4'(TICKS_6T - 1);
    assign periph_tick = (presc_reg == presc_top);
    assign pin_tick    = cnt_last_reg & ~cnt_sync_reg[1];
    // clock-out drives the pin, so pin edges never count then
    assign inc = control_reg[BIT_RUN]
               & (control_reg[BIT_COUNT_SRC] ? pin_tick : periph_tick);
    assign overflow = inc & (count_reg == 16'hffff);

    // prescaler free-runs; the run bit only gates increments
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            presc_reg <= 4'h0;
        else if (periph_tick)
            presc_reg <= 4'h0;
        else
            presc_reg <= presc_reg + 4'h1;
    end

    // register writes from software
    // reserved mode bits are dropped on write so they always read zero
    assign wr_control = hit(i_wr, i_addr, OFF_CONTROL);
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            mode_reg <= RST_MODE_CONTROL;
            irq_mask_reg <= RST_IRQ;
        end
        else if (i_wr)
        begin
            if (i_addr == OFF_MODE_CONTROL)
                mode_reg <= {6'h0, i_wdata[BIT_CLOCK_OUT_EN], 1'b0};
            else if (i_addr == OFF_IRQ_MASK)
                irq_mask_reg <= i_wdata[2:0];
        end
    end

    // control register; hardware flag sets win over software writes
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            control_reg <= RST_CONTROL;
        else
        begin
            if (wr_control)
                control_reg <= i_wdata;
            if (trig_fall)
                control_reg[BIT_EXT_FLAG] <= 1'b1;
            if (overflow & ~force_reload & ~clock_out_mode)
                control_reg[BIT_OVF_FLAG] <= 1'b1;
        end
    end

    // reload/capture pair: captured in capture mode, written by software otherwise
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            reload_low_reg  <= RST_RELOAD;
            reload_high_reg <= RST_RELOAD;
        end
        else if (capture_evt)
        begin
            reload_low_reg  <= count_reg[7:0];
            reload_high_reg <= count_reg[15:8];
        end
        else if (hit(i_wr, i_addr, OFF_RELOAD_LOW))
            reload_low_reg <= i_wdata;
        else if (hit(i_wr, i_addr, OFF_RELOAD_HIGH))
            reload_high_reg <= i_wdata;
    end

    // the counter; reload takes precedence over increment and writes
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            count_reg <= {RST_COUNT, RST_COUNT};
        else if (reload_evt)
            count_reg <= {reload_high_reg, reload_low_reg};
        else if (inc)
            count_reg <= count_reg + 16'h0001;
        else if (hit(i_wr, i_addr, OFF_COUNT_LOW))
            count_reg[7:0] <= i_wdata;
        else if (hit(i_wr, i_addr, OFF_COUNT_HIGH))
            count_reg[15:8] <= i_wdata;
    end

    // clock-out toggles on each overflow: half period = reload span
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            clk_out_reg <= 1'b0;
        else if (~clock_out_mode)
            clk_out_reg <= 1'b0;
        else if (overflow)
            clk_out_reg <= ~clk_out_reg;
    end

    // overflow seen outside as a one-clock pulse, registered on the same edge that wraps the count
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            ovf_pulse_reg <= 1'b0;
        else
            ovf_pulse_reg <= overflow;
    end

    // sticky interrupt status, cleared by reading; a new event wins
    assign rd_status = hit(i_rd, i_addr, OFF_IRQ_STATUS);
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            irq_status_reg <= RST_IRQ;
        else
        begin
            if (rd_status)
                irq_status_reg <= RST_IRQ;
            if (overflow & ~force_reload & ~clock_out_mode)
                irq_status_reg[IRQ_OVERFLOW] <= 1'b1;
            if (trig_fall)
                irq_status_reg[IRQ_TRIGGER] <= 1'b1;
            if (capture_evt)
                irq_status_reg[IRQ_CAPTURE] <= 1'b1;
        end
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            rdata_reg <= 8'h00;
        else if (~i_rd)
            rdata_reg <= 8'h00;
        else if (i_addr == OFF_CONTROL)
            rdata_reg <= control_reg;
        else if (i_addr == OFF_MODE_CONTROL)
            rdata_reg <= mode_reg;
        else if (i_addr == OFF_RELOAD_LOW)
            rdata_reg <= reload_low_reg;
        else if (i_addr == OFF_RELOAD_HIGH)
            rdata_reg <= reload_high_reg;
        else if (i_addr == OFF_COUNT_LOW)
            rdata_reg <= count_reg[7:0];
        else if (i_addr == OFF_COUNT_HIGH)
            rdata_reg <= count_reg[15:8];
        else if (i_addr == OFF_IRQ_STATUS)
            rdata_reg <= {5'h00, irq_status_reg};
        else if (i_addr == OFF_IRQ_MASK)
            rdata_reg <= {5'h00, irq_mask_reg};
        else
            rdata_reg <= 8'h00;
    end

    assign o_rdata                 = rdata_reg;
    assign o_external_count_pin    = clk_out_reg;
    assign o_external_count_pin_oe = clock_out_mode;
    assign o_overflow_pulse        = ovf_pulse_reg;
    assign o_irq                   = |(irq_status_reg & irq_mask_reg);

endmodule // timer2_capture_reload_clockout

`default_nettype wire

// File: sim/timer2_sva.sv
// checker: port-level properties of the capture/reload timer
`timescale 1ns/10ps
`default_nettype none
module timer2_sva
    import timer2_pkg::*;
(
    input wire logic       i_sys_clk,
    input wire logic       i_rst,
    input wire logic [7:0] i_addr,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       o_external_count_pin,
    input wire logic       o_external_count_pin_oe,
    input wire logic       o_overflow_pulse,
    input wire logic       o_irq
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // read data stands only in the cycle after a read
    a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
    a_unmapped_reads_zero: assert property (i_rd && (i_addr < OFF_CONTROL || i_addr > OFF_IRQ_MASK)
        |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    a_mode_reserved_zero: assert property (i_rd && i_addr == OFF_MODE_CONTROL
        |=> (o_rdata & 8'hfd) == 8'h00) else $error("reserved mode bits read nonzero");
    // the enable comes from registers, so only a write may move it
    a_oe_after_write: assert property ($changed(o_external_count_pin_oe) |-> $past(i_wr))
        else $error("pin enable moved without a write");
    a_pin_idle_low: assert property (!o_external_count_pin_oe && !$past(o_external_count_pin_oe)
        |-> !o_external_count_pin) else $error("clock-out pin active while disabled");
    a_overflow_one_cycle: assert property (o_overflow_pulse |=> !o_overflow_pulse) else $error("overflow pulse too long");
    // a half period is at least one peripheral tick of six clocks
    a_clockout_half_min: assert property ($changed(o_external_count_pin) |=> $stable(o_external_count_pin)[*5])
        else $error("clock-out half period too short");
    a_irq_drop_cause: assert property ($fell(o_irq) |-> $past(i_rd) || $past(i_wr)) else $error("irq fell on its own");
    c_overflow: cover property (o_overflow_pulse);
    c_irq_rise: cover property ($rose(o_irq));
    c_clockout_on: cover property (o_external_count_pin_oe ##1 $changed(o_external_count_pin));
endmodule // timer2_sva
bind timer2_capture_reload_clockout timer2_sva chk_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_external_count_pin(o_external_count_pin),
    .o_external_count_pin_oe(o_external_count_pin_oe), .o_overflow_pulse(o_overflow_pulse), .o_irq(o_irq));
`default_nettype wire

// File: sim/timer2_pins_model.sv
// model of the pins outside the timer: trigger source and count pulse source
`timescale 1ns/10ps
`default_nettype none
module timer2_pins_model (
    input  wire logic i_sys_clk,
    output logic      o_trigger_pin,
    output logic      o_count_pin
);
    // both lines idle high, as port pins with pull-ups do
    initial
    begin
        o_trigger_pin = 1'b1;
        o_count_pin   = 1'b1;
    end
    // one falling edge, held long enough to pass the synchroniser
    task automatic fall_trigger();
        o_trigger_pin <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
        o_trigger_pin <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
    endtask
    task automatic pulse_count(input int n);
        repeat (n)
        begin
            o_count_pin <= 1'b0;
            repeat (4) @(posedge i_sys_clk);
            o_count_pin <= 1'b1;
            repeat (4) @(posedge i_sys_clk);
        end
    endtask
endmodule // timer2_pins_model
`default_nettype wire

// File: sim/timer2_capture_reload_clockout_tb.sv
// self-checking bench for the capture/reload timer
`timescale 1ns/10ps
`default_nettype none
module timer2_capture_reload_clockout_tb
    import timer2_pkg::*;
;
    logic i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_six_cycle_mode = 0, rd_q = 0;
    logic [7:0] i_addr = 0, i_wdata = 0, o_rdata;
    logic o_pin, o_oe, o_overflow_pulse, o_irq, trig, cnt;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h0eb6_74bd;
    int n_fail = 0, n_compared = 0;
    always #4 i_sys_clk = ~i_sys_clk;
    timer2_pins_model pm_u (.i_sys_clk(i_sys_clk), .o_trigger_pin(trig), .o_count_pin(cnt));
    timer2_capture_reload_clockout dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_six_cycle_mode(i_six_cycle_mode),
        .i_trigger_pin(trig), .i_external_count_pin(o_oe ? o_pin : cnt), .o_external_count_pin(o_pin),
        .o_external_count_pin_oe(o_oe), .o_overflow_pulse(o_overflow_pulse), .o_irq(o_irq));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_sys_clk) i_wr <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_sys_clk) i_rd <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    // cycles until the clock-out pin next changes
    task automatic gap(output int n);
        logic p;
        p = o_pin;
        for (n = 0; n < 1000 && o_pin === p; n++) @(posedge i_sys_clk);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13); s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // read data land one cycle after the strobe, matched in issue order
    always @(posedge i_sys_clk)
    begin
        if (rd_q) check(o_rdata, exp_q.pop_front());
        rd_q <= i_rd;
    end
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        n_fail++;
        conclude();
    end
    initial
    begin
        int n;
        logic [7:0] m;
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        // every register clears on reset; neighbours outside the map read zero
        for (n = 8'hc6; n < 8'hd2; n++) rd(8'(n), 8'h00);
        repeat (3)
        begin
            seed = xs(seed);
            wr(OFF_RELOAD_LOW, seed[7:0]); wr(OFF_RELOAD_HIGH, seed[15:8]);
            rd(OFF_RELOAD_LOW, seed[7:0]); rd(OFF_RELOAD_HIGH, seed[15:8]);
        end
        wr(OFF_MODE_CONTROL, 8'hff); rd(OFF_MODE_CONTROL, 8'h02);
        // capture of a held count, flag stays until software clears it
        wr(OFF_COUNT_LOW, 8'h5a); wr(OFF_COUNT_HIGH, 8'ha5); wr(OFF_CONTROL, 8'h09); pm_u.fall_trigger();
        rd(OFF_RELOAD_LOW, 8'h5a);
        rd(OFF_RELOAD_HIGH, 8'ha5);
        rd(OFF_CONTROL, 8'h49);
        rd(OFF_IRQ_STATUS, 8'h06);
        rd(OFF_CONTROL, 8'h49);
        wr(OFF_CONTROL, 8'h01); wr(OFF_RELOAD_LOW, 8'h33); pm_u.fall_trigger();
        rd(OFF_RELOAD_LOW, 8'h33);
        rd(OFF_CONTROL, 8'h01);
        rd(OFF_IRQ_STATUS, 8'h00);
        // trigger reload, with either baud bit overriding the capture select
        for (n = 0; n < 3; n++)
        begin
            m = (n == 0) ? 8'h08 : (n == 1) ? 8'h19 : 8'h29;
            wr(OFF_CONTROL, m); wr(OFF_RELOAD_LOW, 8'h34); wr(OFF_RELOAD_HIGH, 8'h12);
            wr(OFF_COUNT_LOW, 8'h00); wr(OFF_COUNT_HIGH, 8'h00); pm_u.fall_trigger();
            rd(OFF_COUNT_LOW, 8'h34);
            rd(OFF_COUNT_HIGH, 8'h12);
            rd(OFF_IRQ_STATUS, 8'h02);
        end
        // overflow interrupt: masked first, then unmasked, then cleared by a read
        // clock-out would mute the overflow flag, so turn it off first
        wr(OFF_MODE_CONTROL, 8'h00);
        wr(OFF_CONTROL, 8'h00); wr(OFF_RELOAD_LOW, 8'hf0); wr(OFF_RELOAD_HIGH, 8'hff);
        wr(OFF_COUNT_LOW, 8'hf0); wr(OFF_COUNT_HIGH, 8'hff); wr(OFF_CONTROL, 8'h04);
        for (n = 0; n < 400 && o_overflow_pulse !== 1'b1; n++) @(posedge i_sys_clk);
        check(16'(o_overflow_pulse), 16'h1);
        repeat (2) @(posedge i_sys_clk);
        check(16'(o_irq), 16'h0);
        wr(OFF_IRQ_MASK, 8'h01); check(16'(o_irq), 16'h1);
        rd(OFF_CONTROL, 8'h84);
        wr(OFF_CONTROL, 8'h00); rd(OFF_IRQ_STATUS, 8'h01); check(16'(o_irq), 16'h0);
        // clock-out: half period is the reload span in peripheral ticks
        wr(OFF_MODE_CONTROL, 8'h02); wr(OFF_CONTROL, 8'h0c); check(16'(o_oe), 16'h1);
        gap(n); gap(n); check(16'(n), 16'(16 * TICKS_6T));
        gap(n); check(16'(n), 16'(16 * TICKS_6T));
        i_six_cycle_mode <= 1'b1;
        gap(n); gap(n); gap(n); check(16'(n), 16'(16 * TICKS_12T));
        pm_u.fall_trigger();
        rd(OFF_CONTROL, 8'h4c);
        rd(OFF_IRQ_STATUS, 8'h02);
        check(16'(o_irq), 16'h0);
        // pin edges as count source, then halt and hold
        wr(OFF_CONTROL, 8'h00); wr(OFF_COUNT_LOW, 8'h00); wr(OFF_COUNT_HIGH, 8'h00);
        wr(OFF_CONTROL, 8'h06); check(16'(o_oe), 16'h0);
        pm_u.pulse_count(5); wr(OFF_CONTROL, 8'h00);
        repeat (50) @(posedge i_sys_clk);
        rd(OFF_COUNT_LOW, 8'h05);
        repeat (4) @(posedge i_sys_clk);
        conclude();
    end
endmodule // timer2_capture_reload_clockout_tb
`default_nettype wire
